// ---- hdl/stream_decimating_fir.v ----
/*
 Decimating symmetric FIR with gain, rounding and saturation.
 Input samples land in a history RAM; every factor-th sample a folded
 multiply-accumulate runs over the history, then gain, round, saturate,
 and the result enters a 16-word output FIFO.
 Assumes one clock, synchronous reset, upstream/downstream stream logic,
 and software loading symmetric even-length coefficient sets.
*/
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "fir_defs.vh"
module stream_decimating_fir #(
	parameter OUT_RES = 16,
	parameter NUM_CHAN = 1,
	parameter IN_W = 16,
	parameter HIST_AW = 10
) (
	input wire clk,
	input wire srst,
	input wire [`ADDR_W-1:0] regAddr,
	input wire [31:0] regWdata,
	input wire regWrite,
	input wire regRead,
	output reg [31:0] regRdata,
	input wire [2*IN_W-1:0] sTdata,
	input wire sTuser,
	input wire sTvalid,
	output reg sTready,
	output reg [2*OUT_RES-1:0] mTdata,
	output reg mTvalid,
	input wire mTready
);
	localparam ACC_W = 48;
	localparam ST_IDLE = 4'b0001;
	localparam ST_MAC = 4'b0010;
	localparam ST_SCALE = 4'b0100;
	localparam ST_PUSH = 4'b1000;
	localparam HDEPTH = 1 << HIST_AW;
	localparam OW = 2 * OUT_RES;
	localparam [`COEF_AW-1:0] HALF_MULT = `TAP_MULT / 2;

	// ******************************************************
	// control registers
	// ******************************************************
	reg [`DECIM_W-1:0] decim_q;
	reg [`GAIN_W-1:0] gain_q;
	reg [1:0] ctrl_q;
	reg syncSeen_q;
	reg [31:0] rdMux;

	function isCoef;
		input [`ADDR_W-1:0] a;
		begin
			isCoef = (a >= `REG_COEF_BASE) &&
				(a[`ADDR_W-2:2] < `COEF_DEPTH);
		end
	endfunction

	// ******************************************************
	// coefficient store (dual port: host side, datapath side)
	// ******************************************************
	reg [`COEF_W-1:0] coefStore [0:`COEF_DEPTH-1];
	reg [`COEF_W-1:0] coefDp_q;
	wire [`COEF_AW-1:0] hostIdx;
	// index counts from the coefficient window base, as the datapath does
	assign hostIdx = {1'b0, regAddr[`ADDR_W-2:2]};

	always @(posedge clk) begin
		if (regWrite && isCoef(regAddr)) begin
			coefStore[hostIdx] <= regWdata[`COEF_W-1:0];
		end
		coefDp_q <= coefStore[k_q];
	end

	// ******************************************************
	// register port
	// ******************************************************
	always @* begin
		case (regAddr)
		`REG_DECIM: rdMux = {{(32-`DECIM_W){1'b0}}, decim_q};
		`REG_GAIN: rdMux = {{(32-`GAIN_W){1'b0}}, gain_q};
		`REG_CTRL: rdMux = {30'h0, ctrl_q};
		default: rdMux = 32'h0;
		endcase
	end

	reg [3:0] state_q;
	reg fifoFull;
	always @(posedge clk) begin
		if (srst) begin
			decim_q <= `DECIM_RST;
			gain_q <= `GAIN_RST;
			ctrl_q <= `CTRL_RST;
			regRdata <= 32'h0;
		end else begin
			if (regWrite && regAddr == `REG_DECIM) begin
				if (regWdata[`DECIM_W-1:0] < `DECIM_MIN) begin
					decim_q <= `DECIM_MIN;
				end else if (regWdata[`DECIM_W-1:0] > `DECIM_MAX) begin
					decim_q <= `DECIM_MAX;
				end else begin
					decim_q <= regWdata[`DECIM_W-1:0];
				end
			end
			if (regWrite && regAddr == `REG_GAIN) begin
				gain_q <= regWdata[`GAIN_W-1:0];
			end
			if (regWrite && regAddr == `REG_CTRL) begin
				ctrl_q <= regWdata[1:0];
			end
			// status: idle flag, fifo full, sync seen
			if (regRead && regAddr == `REG_STATUS) begin
				regRdata <= {29'h0, syncSeen_q, fifoFull,
					state_q == ST_IDLE};
			end else if (regRead && isCoef(regAddr)) begin
				regRdata <= {{(32-`COEF_W){1'b0}},
					coefStore[hostIdx]};
			end else if (regRead) begin
				regRdata <= rdMux;
			end else begin
				regRdata <= 32'h0;
			end
		end
	end

	// ******************************************************
	// input history and decimation phase
	// ******************************************************
	reg [2*IN_W-1:0] hist [0:HDEPTH-1];
	reg [HIST_AW-1:0] wrPtr_q;
	reg [`DECIM_W-1:0] phase_q;
	reg [HIST_AW-1:0] newest_q;
	wire accept;
	wire syncHit;
	assign accept = sTvalid && sTready;
	assign syncHit = accept && sTuser && ctrl_q[`CTRL_SYNC_EN];

	always @(posedge clk) begin
		if (accept) begin
			hist[wrPtr_q] <= sTdata;
		end
	end

	// ******************************************************
	// folded mac: taps = 2*half, half <= 14*decim
	// ******************************************************
	reg [`COEF_AW-1:0] half_q;
	reg [`COEF_AW-1:0] k_q;
	reg macVal_q;
	reg [2*IN_W-1:0] a_q;
	reg [2*IN_W-1:0] b_q;
	reg signed [ACC_W-1:0] accI_q;
	reg signed [ACC_W-1:0] accQ_q;
	reg [OW-1:0] result_q;
	wire [`COEF_AW-1:0] halfMax;
	// 28 taps per decimation step, folded to 14 coefficient products
	assign halfMax = decim_q * HALF_MULT;
	// history is never deeper than the store index, so a slice is safe
	wire [HIST_AW-1:0] kExt;
	assign kExt = k_q[HIST_AW-1:0];
	wire [HIST_AW-1:0] fullTaps;
	assign fullTaps = {half_q[HIST_AW-2:0], 1'b0};
	wire [HIST_AW-1:0] nearIdx;
	wire [HIST_AW-1:0] farIdx;
	assign nearIdx = newest_q - kExt;
	assign farIdx = newest_q - fullTaps + kExt + 1'b1;

	function signed [ACC_W-1:0] foldMul;
		input [IN_W-1:0] x;
		input [IN_W-1:0] y;
		input [`COEF_W-1:0] c;
		reg signed [IN_W:0] s;
		begin
			s = $signed({x[IN_W-1], x}) + $signed({y[IN_W-1], y});
			foldMul = s * $signed(c);
		end
	endfunction

	function [OUT_RES-1:0] roundSat;
		input signed [ACC_W-1:0] acc;
		input [`GAIN_W-1:0] g;
		reg signed [ACC_W+`GAIN_W:0] p;
		reg signed [ACC_W+`GAIN_W:0] r;
		reg signed [ACC_W+`GAIN_W:0] hi;
		reg signed [ACC_W+`GAIN_W:0] lo;
		begin
			p = acc * $signed({1'b0, g});
			// drop gain fraction and coefficient fraction
			r = (p + (1 <<< (`GAIN_FRAC + `COEF_W - 2))) >>>
				(`GAIN_FRAC + `COEF_W - 1);
			hi = (1 <<< (OUT_RES - 1)) - 1;
			lo = -(1 <<< (OUT_RES - 1));
			if (r > hi) begin
				roundSat = {1'b0, {(OUT_RES-1){1'b1}}};
			end else if (r < lo) begin
				roundSat = {1'b1, {(OUT_RES-1){1'b0}}};
			end else begin
				roundSat = r[OUT_RES-1:0];
			end
		end
	endfunction

	// ******************************************************
	// output fifo
	// ******************************************************
	reg pushValid_q;
	wire fifoInReady;
	wire [OW-1:0] fifoData;
	wire fifoValid;
	wire fifoTake;
	assign fifoTake = fifoValid && (!mTvalid || mTready);

	stream_fifo #(
		.WIDTH(OW),
		.DEPTH(`FIFO_DEPTH),
		.AW(4)
	) outFifo (
		.clk(clk),
		.srst(srst),
		.inData(result_q),
		.inValid(pushValid_q),
		.inReady(fifoInReady),
		.outData(fifoData),
		.outValid(fifoValid),
		.outReady(!mTvalid || mTready)
	);

	// ******************************************************
	// sequencer
	// ******************************************************
	always @(posedge clk) begin
		if (srst) begin
			state_q <= ST_IDLE;
			wrPtr_q <= {HIST_AW{1'b0}};
			newest_q <= {HIST_AW{1'b0}};
			phase_q <= {`DECIM_W{1'b0}};
			sTready <= 1'b0;
			half_q <= {`COEF_AW{1'b0}};
			k_q <= {`COEF_AW{1'b0}};
			macVal_q <= 1'b0;
			a_q <= {(2*IN_W){1'b0}};
			b_q <= {(2*IN_W){1'b0}};
			accI_q <= {ACC_W{1'b0}};
			accQ_q <= {ACC_W{1'b0}};
			result_q <= {OW{1'b0}};
			pushValid_q <= 1'b0;
			syncSeen_q <= 1'b0;
			fifoFull <= 1'b0;
		end else begin
			fifoFull <= !fifoInReady;
			pushValid_q <= 1'b0;
			// stall intake while the fifo has no room for a result
			sTready <= (state_q == ST_IDLE) && !accept &&
				fifoInReady && ctrl_q[`CTRL_RUN];
			if (syncHit) begin
				syncSeen_q <= 1'b1;
			end else if (regRead && regAddr == `REG_STATUS) begin
				syncSeen_q <= 1'b0;
			end
			case (state_q)
			ST_IDLE: begin
				if (accept) begin
					wrPtr_q <= wrPtr_q + 1'b1;
					newest_q <= wrPtr_q;
					if (syncHit || phase_q + 1'b1 >= decim_q) begin
						// sync sample becomes output phase zero
						phase_q <= {`DECIM_W{1'b0}};
						half_q <= halfMax;
						k_q <= {`COEF_AW{1'b0}};
						accI_q <= {ACC_W{1'b0}};
						accQ_q <= {ACC_W{1'b0}};
						state_q <= ST_MAC;
					end else begin
						phase_q <= phase_q + 1'b1;
					end
				end
			end
			ST_MAC: begin
				// pair and coefficient fetched together, summed a cycle later
				a_q <= hist[nearIdx];
				b_q <= hist[farIdx];
				macVal_q <= (k_q < half_q);
				if (macVal_q) begin
					accI_q <= accI_q + foldMul(a_q[IN_W-1:0],
						b_q[IN_W-1:0], coefDp_q);
					if (NUM_CHAN == 2) begin
						accQ_q <= accQ_q + foldMul(a_q[2*IN_W-1:IN_W],
							b_q[2*IN_W-1:IN_W], coefDp_q);
					end
				end
				if (k_q < half_q + 2'd2) begin
					k_q <= k_q + 1'b1;
				end else begin
					state_q <= ST_SCALE;
				end
			end
			ST_SCALE: begin
				result_q <= {(NUM_CHAN == 2) ? roundSat(accQ_q, gain_q) :
					{OUT_RES{1'b0}}, roundSat(accI_q, gain_q)};
				state_q <= ST_PUSH;
			end
			ST_PUSH: begin
				if (fifoInReady) begin
					pushValid_q <= 1'b1;
					state_q <= ST_IDLE;
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	// ******************************************************
	// stream master output register
	// ******************************************************
	always @(posedge clk) begin
		if (srst) begin
			mTvalid <= 1'b0;
			mTdata <= {OW{1'b0}};
		end else if (fifoTake) begin
			mTvalid <= 1'b1;
			mTdata <= fifoData;
		end else if (mTready) begin
			mTvalid <= 1'b0;
		end
	end
endmodule // stream_decimating_fir
`default_nettype wire

// ---- hdl/fir_defs.vh ----
/*
 Shared constants for the decimating FIR block: register offsets, field
 positions, reset values and limits.
 Assumes a plain register port (address, strobes, read data next cycle).
*/
//
// Notes on behaviour
// - decimation factor ranges from two to thirty-two
// - tap count up to 28 times decimation
// - programmable gain scales filter result before rounding
// - round then saturate to output width, no wrap
// - sideband sync bit realigns decimation phase
// - coefficients are 18-bit words in dual-port store
// - host writes and reads back coefficient store
// - control and status registers are 32 bits wide
// - samples in and out by valid/ready streams
// - output component width fixed at 16 or 24
// - channel setting: one real, two complex pairs
// - reset returns every control register to initial value
`ifndef FIR_DEFS_VH
`define FIR_DEFS_VH

// ******************************************************
// register map (byte addresses)
// ******************************************************
`define REG_DECIM 12'h000
`define REG_GAIN 12'h004
`define REG_CTRL 12'h008
`define REG_STATUS 12'h010
`define REG_COEF_BASE 12'h800
`define ADDR_W 12

// ******************************************************
// fields and reset values
// ******************************************************
`define DECIM_W 6
`define DECIM_MIN 6'h02
`define DECIM_MAX 6'h20
`define DECIM_RST 6'h02
`define GAIN_W 18
`define GAIN_RST 18'h10000
`define GAIN_FRAC 16
`define CTRL_SYNC_EN 0
`define CTRL_RUN 1
`define CTRL_RST 2'h3
`define TAP_MULT 28
`define COEF_W 18
`define COEF_DEPTH 896
`define COEF_AW 10
`define FIFO_DEPTH 16

`endif

// ---- hdl/stream_fifo.v ----
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
	parameter WIDTH = 48,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire srst,
	input wire [WIDTH-1:0] inData,
	input wire inValid,
	output wire inReady,
	output wire [WIDTH-1:0] outData,
	output wire outValid,
	input wire outReady
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_q;
	reg [AW-1:0] rdPtr_q;
	reg [AW:0] count_q;
	wire push;
	wire pop;

	assign inReady = (count_q != DEPTH[AW:0]);
	assign outValid = (count_q != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_q];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always @(posedge clk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule // stream_fifo
`default_nettype wire

// ---- testbench/fir_monitor.sv ----
/* port checker for the decimating fir
 assumes a bind onto stream_decimating_fir, one clock domain */
`timescale 1ns/1ps
`default_nettype none
`include "fir_defs.vh"
module fir_monitor #(
	parameter OUT_RES = 16,
	parameter NUM_CHAN = 1,
	parameter IN_W = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [`ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regRdata,
	input wire logic [2*IN_W-1:0] sTdata,
	input wire logic sTuser,
	input wire logic sTvalid,
	input wire logic sTready,
	input wire logic [2*OUT_RES-1:0] mTdata,
	input wire logic mTvalid,
	input wire logic mTready
);
// ****
// properties
// ****
default clocking @(posedge clk); endclocking
default disable iff (srst);
logic runQ;
function automatic logic [31:0] clampD(input logic [31:0] v);
	return v < 32'h2 ? 32'h2 : v > 32'h20 ? 32'h20 : v;
endfunction
// mirror of the run bit, so a halt can be judged at the port
always @(posedge clk)
	if (srst)
		runQ <= 1'b1;
	else if (regWrite && regAddr == `REG_CTRL)
		runQ <= regWdata[`CTRL_RUN];
a_out_held: assert property (
	mTvalid && !mTready |=> mTvalid && $stable(mTdata))
	else $error("output changed while stalled");
a_input_gap: assert property (
	sTvalid && sTready |=> !sTready)
	else $error("input accepted back to back");
a_reset_quiet: assert property (
	$fell(srst) |-> !mTvalid && !sTready && regRdata == 32'h0)
	else $error("outputs active after reset");
a_read_idle: assert property (
	!regRead |=> regRdata == 32'h0)
	else $error("read data without a read");
a_gain_back: assert property (
	regWrite && regAddr == `REG_GAIN ##1 regRead && regAddr == `REG_GAIN
	|=> regRdata == {14'h0, $past(regWdata[17:0], 2)})
	else $error("gain readback wrong");
a_decim_clamp: assert property (
	regWrite && regAddr == `REG_DECIM && regWdata < 32'h40 ##1
	regRead && regAddr == `REG_DECIM
	|=> regRdata == clampD($past(regWdata, 2)))
	else $error("decimation not clamped");
a_coef_back: assert property (
	regWrite && regAddr >= `REG_COEF_BASE && regAddr < 12'hf00 ##1
	regRead && $stable(regAddr)
	|=> regRdata[17:0] == $past(regWdata[17:0], 2))
	else $error("coefficient readback wrong");
a_halt_input: assert property (
	!runQ ##1 !runQ |-> !sTready)
	else $error("input taken while halted");
a_real_q: assert property (
	mTvalid && NUM_CHAN == 1 |-> mTdata[2*OUT_RES-1:OUT_RES] == '0)
	else $error("imaginary half not zero");
endmodule // fir_monitor
bind stream_decimating_fir fir_monitor #(.OUT_RES(OUT_RES),
	.NUM_CHAN(NUM_CHAN), .IN_W(IN_W)) mon (.clk(clk), .srst(srst),
	.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
	.regRead(regRead), .regRdata(regRdata), .sTdata(sTdata),
	.sTuser(sTuser), .sTvalid(sTvalid), .sTready(sTready),
	.mTdata(mTdata), .mTvalid(mTvalid), .mTready(mTready));
`default_nettype wire

// ---- testbench/stream_partner.sv ----
/* upstream source and downstream sink around the fir streams
 assumes the bench sets limit, syncAt, level, slow and hold */
`timescale 1ns/1ps
`default_nettype none
module stream_partner #(
	parameter IN_W = 16,
	parameter OUT_RES = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [31:0] limit,
	input wire logic [31:0] syncAt,
	input wire logic [2*IN_W-1:0] level,
	input wire logic slow,
	input wire logic hold,
	input wire logic sTready,
	output logic [2*IN_W-1:0] sTdata,
	output logic sTuser,
	output logic sTvalid,
	input wire logic mTvalid,
	input wire logic [2*OUT_RES-1:0] mTdata,
	output logic mTready,
	output logic [31:0] sent,
	output logic [31:0] got,
	output logic [2*OUT_RES-1:0] lastOut
);
// ****
// handshakes
// ****
logic [7:0] rnd;
always @(posedge clk) begin
	rnd <= {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
	mTready <= !hold && !(slow && rnd[1]);
	if (mTvalid && mTready) begin
		got <= got + 1;
		lastOut <= mTdata;
	end
	if (sTvalid && sTready) begin
		sent <= sent + 1;
		sTvalid <= 1'b0;
		// released lines flip so a stale sample never looks fresh
		sTdata <= ~sTdata;
		sTuser <= ~sTuser;
	end else if (!sTvalid && sent < limit && !(slow && rnd[0])) begin
		sTvalid <= 1'b1;
		sTdata <= level;
		sTuser <= sent == syncAt;
	end
	if (srst) begin
		rnd <= 8'h5a;
		mTready <= 1'b0;
		sTvalid <= 1'b0;
		sTdata <= '0;
		sTuser <= 1'b0;
		sent <= 32'h0;
		got <= 32'h0;
	end
end
endmodule // stream_partner
`default_nettype wire

// ---- testbench/test_stream_decimating_fir.sv ----
/* self-checking bench for the decimating fir
 assumes the bound checker and stream_partner on the streams */
`timescale 1ns/1ps
`default_nettype none
`include "fir_defs.vh"
module test_stream_decimating_fir;
logic clk, srst, regWrite, regRead, slow, hold, sTuser, sTvalid, sTready;
logic mTvalid, mTready;
logic [11:0] regAddr;
logic [31:0] regWdata, regRdata, limit, syncAt, sent, got, seed, q;
logic [31:0] sTdata, mTdata, level, lastOut;
logic [17:0] g;
logic [15:0] x;
int n_errors, checks, i, d;
logic [31:0] dv[6] = '{32'h0, 32'h1, 32'h2, 32'h20, 32'h21, 32'h3f};
logic [17:0] gt[5] = '{18'h10000, 18'h8000, 18'h8000, 18'h3ffff, 18'h3ffff};
logic [15:0] xt[5] = '{16'h1234, 16'h3, 16'hfffd, 16'h7fff, 16'h8000};
stream_decimating_fir #(.OUT_RES(16), .NUM_CHAN(1), .IN_W(16)) dut (
	.clk(clk), .srst(srst), .regAddr(regAddr),
	.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
	.regRdata(regRdata), .sTdata(sTdata), .sTuser(sTuser),
	.sTvalid(sTvalid), .sTready(sTready), .mTdata(mTdata),
	.mTvalid(mTvalid), .mTready(mTready));
stream_partner #(.IN_W(16), .OUT_RES(16)) far (.clk(clk), .srst(srst),
	.limit(limit), .syncAt(syncAt), .level(level), .slow(slow),
	.hold(hold), .sTready(sTready), .sTdata(sTdata), .sTuser(sTuser),
	.sTvalid(sTvalid), .mTvalid(mTvalid), .mTdata(mTdata),
	.mTready(mTready), .sent(sent), .got(got), .lastOut(lastOut));
// ****
// helpers
// ****
function automatic logic [31:0] xs(input logic [31:0] s);
	s = s ^ (s << 13);
	s = s ^ (s >> 17);
	return s ^ (s << 5);
endfunction
function automatic logic [15:0] expY(input logic [17:0] gn,
	input logic [15:0] xn);
	longint p;
	p = (longint'($signed(xn)) * longint'(gn) + 64'sh8000) >>> 16;
	return p > 64'sh7fff ? 16'h7fff : p < -64'sh8000 ? 16'h8000 : p[15:0];
endfunction
task chk(input logic [31:0] seen, input logic [31:0] want);
	checks++;
	if (seen !== want) begin
		n_errors++;
		$display("BAD %0t seen %h want %h", $time, seen, want);
	end
endtask
// every access is a write or idle cycle, then a read right behind it
task automatic acc(input logic [11:0] a, input logic [31:0] dw,
	input logic w);
	@(posedge clk);
	regWrite <= w;
	regAddr <= a;
	regWdata <= dw;
	@(posedge clk);
	regWrite <= 1'b0;
	regRead <= 1'b1;
	@(posedge clk);
	regRead <= 1'b0;
	#1 q = regRdata;
endtask
// extra quiet cycles expose surplus outputs
task automatic send(input int n, input int outs);
	int k;
	outs = outs + got;
	@(posedge clk);
	limit <= limit + n;
	@(posedge clk);
	for (k = 0; k < 9000 && (sent != limit || got != outs); k++)
		@(posedge clk);
	repeat (300) @(posedge clk);
	chk(got, outs);
endtask
task tally_and_finish;
	if (n_errors == 0 && checks > 0) begin
		$display("bench passed");
	end else begin
		$display("bench failed");
	end
	$finish;
endtask
// ****
// sequence
// ****
initial begin
	clk = 1'b0;
	forever #5 clk = ~clk;
end
initial begin
	// nearly three times the expected run
	repeat (80000) @(posedge clk);
	n_errors++;
	tally_and_finish;
end
initial begin
	srst = 1'b1;
	regWrite = 1'b0;
	regRead = 1'b0;
	regAddr = '0;
	regWdata = '0;
	limit = '0;
	syncAt = '1;
	level = '0;
	slow = 1'b0;
	hold = 1'b0;
	seed = 32'hf338;
	repeat (2) @(posedge clk);
	srst <= 1'b0;
	acc(`REG_DECIM, 0, 0);
	chk(q, 32'h2);
	acc(`REG_GAIN, 0, 0);
	chk(q, 32'h10000);
	acc(`REG_CTRL, 32'h0, 0);
	chk(q, 32'h3);
	acc(`REG_CTRL, 32'h0, 1);
	chk(q, 32'h0);
	acc(`REG_CTRL, 32'h3, 1);
	acc(12'h00c, 32'hffffffff, 1);
	chk(q, 32'h0);
	for (i = 0; i < 10; i++) begin
		seed = xs(seed);
		d = i < 6 ? dv[i] : seed[5:0];
		acc(`REG_DECIM, d, 1);
		chk(q, d < 2 ? 2 : d > 32 ? 32 : d);
	end
	acc(`REG_DECIM, 32'h2, 1);
	// set coefficient 0 and zero the rest of the folded range so long filters never read unknowns
	for (i = 0; i < 448; i++) begin
		seed = xs(seed);
		g = i == 0 ? 18'h10000 : 18'h0;
		acc(12'(`REG_COEF_BASE + 4 * i), {seed[31:18], g}, 1);
		chk(q[17:0], g);
	end
	// 900 samples fill the history before the long filters run
	for (i = 0; i < 9; i++) begin
		seed = xs(seed);
		g = i < 5 ? gt[i] : seed[17:0];
		x = i < 5 ? xt[i] : seed[31:16];
		level <= {seed[15:0], x};
		acc(`REG_GAIN, g, 1);
		send(100, 50);
		chk(lastOut[15:0], expY(g, x));
	end
	acc(`REG_DECIM, 32'h4, 1);
	syncAt <= limit;
	send(1, 1);
	syncAt <= limit + 2;
	send(3, 1);
	acc(`REG_STATUS, 0, 0);
	chk(q[2], 1);
	acc(`REG_STATUS, 0, 0);
	chk(q[2], 0);
	send(4, 1);
	send(3, 0);
	slow <= 1'b1;
	for (i = 0; i < 4; i++) begin
		seed = xs(seed);
		d = i == 0 ? 3 : i == 1 ? 32 : 2 + seed[4:0] % 31;
		acc(`REG_DECIM, d, 1);
		syncAt <= limit;
		send(1 + 2 * d, 3);
	end
	acc(`REG_DECIM, 32'h2, 1);
	hold <= 1'b1;
	slow <= 1'b0;
	limit <= limit + 60;
	repeat (800) @(posedge clk);
	d = sent;
	acc(`REG_STATUS, 0, 0);
	chk(q[1], 1);
	chk(sent, d);
	hold <= 1'b0;
	slow <= 1'b1;
	send(0, 30);
	tally_and_finish;
end
endmodule // test_stream_decimating_fir
`default_nettype wire
